// ---- hdl/icd_pkg.sv ----
// shared constants and types of the instruction cycle decoder
package icd_pkg;
	// ---------------------------------------------------------------
	// instruction classes
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ICD_CL_PLAIN = 3'h0, // straight-line instruction
		ICD_CL_JUMP = 3'h1, // unconditional branch
		ICD_CL_CALL = 3'h2, // subroutine call
		ICD_CL_RET = 3'h3, // return
		ICD_CL_COND = 3'h4, // conditional branch
		ICD_CL_BITCLR = 3'h5 // bit test that also clears
	} icd_class_e;
	// condition selector for conditional branches
	typedef enum logic [2:0] {
		ICD_CO_NONE = 3'h0,
		ICD_CO_ACCZ = 3'h1, // accumulator zero
		ICD_CO_ACCNZ = 3'h2, // accumulator nonzero
		ICD_CO_C = 3'h3, // carry set
		ICD_CO_NC = 3'h4, // carry clear
		ICD_CO_BIT = 3'h5, // addressed bit set
		ICD_CO_NBIT = 3'h6, // addressed bit clear
		ICD_CO_EXT = 3'h7 // datapath supplies outcome
	} icd_cond_e;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int ICD_CLK_NS = 100; // clock period
	localparam int ICD_CYC_PER_MC = 1; // one clock per machine cycle
	localparam logic [3:0] ICD_MAX_CYC = 4'h8; // longest instruction
	localparam logic [3:0] ICD_RESET_CYC = 4'h0; // cycle index loaded when an opcode is accepted
	localparam logic [7:0] ICD_NOP = 8'h00;
endpackage

// ---- hdl/icd_table.sv ----
// opcode table: length, base cycles, taken cycles, class, condition
`timescale 1ns/1ns
module icd_table
	import icd_pkg::*;
(
	input wire logic [7:0] op,
	output logic [1:0] len,
	output logic [3:0] cyc,
	output logic [3:0] cyc_tk,
	output icd_class_e cls,
	output icd_cond_e cond
);
	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	// defaults: one-byte single-cycle plain instruction
	always_comb begin
		len = 2'h1;
		cyc = 4'h1;
		cyc_tk = 4'h1;
		cls = ICD_CL_PLAIN;
		cond = ICD_CO_NONE;
		if (op[4:0] == 5'h01) begin // absolute jump
			len = 2'h2; cyc = 4'h4; cls = ICD_CL_JUMP;
		end else if (op[4:0] == 5'h11) begin // absolute call
			len = 2'h2; cyc = 4'h7; cls = ICD_CL_CALL;
		end else begin
			case (op[7:4])
			4'h4, 4'h5, 4'h6: begin // logic group
				if (op[3]) begin
					cyc = 4'h1;
				end else begin
					case (op[2:0])
					3'h2: begin len = 2'h2; cyc = 4'h3; end
					3'h3: begin len = 2'h3; cyc = 4'h3; end
					3'h4, 3'h5: begin len = 2'h2; cyc = 4'h2; end
					3'h6, 3'h7: cyc = 4'h2;
					3'h0: begin // conditional jumps
						len = 2'h2;
						if (op[7:4] == 4'h6) begin
							cyc = 4'h3; cyc_tk = 4'h5; cond = ICD_CO_ACCZ;
						end else begin
							cyc = 4'h2; cyc_tk = 4'h4;
							cond = (op[7:4] == 4'h4) ? ICD_CO_C : ICD_CO_NC;
						end
						cls = ICD_CL_COND;
					end
					default: begin len = 2'h2; cyc = 4'h2; end
					endcase
				end
			end
			4'h2, 4'h3: begin // arithmetic group
				if (op[3] || op[2:0] == 3'h3) cyc = 4'h1;
				else begin
					case (op[2:0])
					3'h0: begin // bit jumps
						len = 2'h3; cyc = 4'h4; cyc_tk = 4'h6; cls = ICD_CL_COND;
						cond = op[4] ? ICD_CO_NBIT : ICD_CO_BIT;
					end
					3'h2: begin cyc = 4'h8; cls = ICD_CL_RET; end
					3'h4, 3'h5: begin len = 2'h2; cyc = 4'h2; end
					default: cyc = 4'h2;
					endcase
				end
			end
			4'h0, 4'h1: begin // inc/dec/rotates
				case (op)
				8'h02: begin len = 2'h3; cyc = 4'h5; cls = ICD_CL_JUMP; end
				8'h12: begin len = 2'h3; cyc = 4'h7; cls = ICD_CL_CALL; end
				8'h10: begin
					len = 2'h3; cyc = 4'h4; cyc_tk = 4'h6;
					cls = ICD_CL_BITCLR; cond = ICD_CO_BIT;
				end
				8'h03, 8'h13: cyc = 4'h1;
				8'h05, 8'h15: begin len = 2'h2; cyc = 4'h3; end
				8'h06, 8'h07, 8'h16, 8'h17: cyc = 4'h3;
				default: cyc = 4'h1;
				endcase
				if (op == ICD_NOP) cyc = 4'h1;
			end
			4'h7: begin
				case (op[3:0])
				4'h2: begin len = 2'h2; cyc = 4'h2; end
				4'h3: begin cyc = 4'h6; cls = ICD_CL_JUMP; end
				4'h4, 4'h5: begin len = 2'h2; cyc = 4'h2; end
				4'h6, 4'h7: begin len = 2'h2; cyc = 4'h2; end
				default: begin
					if (op[3]) begin len = 2'h2; cyc = 4'h2; end
					else begin // jump if accumulator nonzero
						len = 2'h2; cyc = 4'h3; cyc_tk = 4'h5;
						cls = ICD_CL_COND; cond = ICD_CO_ACCNZ;
					end
				end
				endcase
				if (op == 8'h75) begin len = 2'h3; cyc = 4'h3; end
			end
			4'h8: begin
				case (op[3:0])
				4'h0: begin len = 2'h2; cyc = 4'h4; cls = ICD_CL_JUMP; end
				4'h2: begin len = 2'h2; cyc = 4'h2; end
				4'h3: cyc = 4'h8;
				4'h4: cyc = 4'h4;
				4'h5: begin len = 2'h3; cyc = 4'h3; end
				4'h6, 4'h7: begin len = 2'h2; cyc = 4'h3; end
				default: begin len = 2'h2; cyc = 4'h2; end
				endcase
			end
			4'h9: begin
				case (op[3:0])
				4'h0: begin len = 2'h3; cyc = 4'h3; end
				4'h2: begin len = 2'h2; cyc = 4'h3; end
				4'h3: cyc = 4'h7;
				4'h4, 4'h5: begin len = 2'h2; cyc = 4'h2; end
				default: cyc = op[3] ? 4'h1 : 4'h2;
				endcase
			end
			4'hA: begin
				case (op[3:0])
				4'h0, 4'h2: begin len = 2'h2; cyc = 4'h2; end
				4'h3: cyc = 4'h4;
				4'h4: cyc = 4'h4;
				4'h5: cyc = 4'h1;
				4'h6, 4'h7: begin len = 2'h2; cyc = 4'h3; end
				default: begin len = 2'h2; cyc = 4'h3; end
				endcase
			end
			4'hB: begin
				case (op[3:0])
				4'h0, 4'h2: begin
					len = 2'h2; cyc = (op[1]) ? 4'h3 : 4'h2;
				end
				4'h3: cyc = 4'h1;
				default: begin
					len = 2'h3; cyc = 4'h4; cyc_tk = 4'h6;
					cls = ICD_CL_COND; cond = ICD_CO_EXT;
				end
				endcase
			end
			4'hC: begin
				case (op[3:0])
				4'h0: begin len = 2'h2; cyc = 4'h5; end
				4'h2: begin len = 2'h2; cyc = 4'h3; end
				4'h3: cyc = 4'h1;
				4'h4: cyc = 4'h4;
				4'h5: begin len = 2'h2; cyc = 4'h4; end
				4'h6, 4'h7: cyc = 4'h4;
				default: cyc = 4'h3;
				endcase
			end
			4'hD: begin
				case (op[3:0])
				4'h0: begin len = 2'h2; cyc = 4'h4; end
				4'h2: begin len = 2'h2; cyc = 4'h3; end
				4'h3: cyc = 4'h1;
				4'h4: cyc = 4'h1;
				4'h5: begin
					len = 2'h3; cyc = 4'h4; cyc_tk = 4'h6;
					cls = ICD_CL_COND; cond = ICD_CO_EXT;
				end
				4'h6, 4'h7: cyc = 4'h4;
				default: begin
					len = 2'h2; cyc = 4'h3; cyc_tk = 4'h5;
					cls = ICD_CL_COND; cond = ICD_CO_EXT;
				end
				endcase
			end
			4'hE: begin
				case (op[3:0])
				4'h0: cyc = 4'h6;
				4'h2, 4'h3: cyc = 4'h5;
				4'h4: cyc = 4'h1;
				4'h5: begin len = 2'h2; cyc = 4'h2; end
				4'h6, 4'h7: cyc = 4'h2;
				default: cyc = 4'h1;
				endcase
			end
			default: begin // 0xF_
				case (op[3:0])
				4'h0: cyc = 4'h5;
				4'h2, 4'h3: cyc = 4'h4;
				4'h4: cyc = 4'h1;
				4'h5: begin len = 2'h2; cyc = 4'h2; end
				4'h6, 4'h7: cyc = 4'h2;
				default: cyc = 4'h2;
				endcase
			end
			endcase
		end
	end
endmodule // icd_table

// ---- hdl/icd_cond.sv ----
// branch outcome evaluation
`timescale 1ns/1ns
module icd_cond
	import icd_pkg::*;
(
	input icd_cond_e cond,
	input wire logic acc_zero,
	input wire logic carry,
	input wire logic bit_val,
	input wire logic ext_taken,
	output logic taken
);
	// ---------------------------------------------------------------
	// outcome
	// ---------------------------------------------------------------
	// pick the flag that the condition names
	always_comb begin
		case (cond)
		ICD_CO_ACCZ: taken = acc_zero;
		ICD_CO_ACCNZ: taken = !acc_zero;
		ICD_CO_C: taken = carry;
		ICD_CO_NC: taken = !carry;
		ICD_CO_BIT: taken = bit_val;
		ICD_CO_NBIT: taken = !bit_val;
		ICD_CO_EXT: taken = ext_taken;
		default: taken = 1'b0;
		endcase
	end
endmodule // icd_cond

// ---- hdl/icd_decoder.sv ----
// instruction cycle decoder: opcode to length and cycle sequencing
`timescale 1ns/1ns
module icd_decoder
	import icd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire logic [7:0] op,
	input wire logic acc_zero,
	input wire logic carry,
	input wire logic bit_val,
	input wire logic ext_taken,
	output logic op_ready,
	output logic busy,
	output logic done,
	output logic [7:0] cur_op,
	output logic [1:0] cur_len,
	output logic [3:0] cur_cyc,
	output logic [3:0] cyc_idx,
	output logic cur_taken,
	output logic bit_clear
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ICD_ST_IDLE = 2'h0, // waiting for an opcode
		ICD_ST_RUN = 2'h1 // counting execution cycles
	} icd_state_e;

	typedef struct packed {
		icd_state_e st; // sequencer state
		logic [7:0] op; // opcode in execution
		logic [1:0] len; // its byte length
		logic [3:0] cyc; // its total cycles
		logic [3:0] idx; // cycles used so far
		logic taken; // branch outcome
		logic bclr; // clear tested bit at end
		logic bpls; // bit-clear pulse, rides with done
		logic done; // pulse in the cycle after the last cycle
	} icd_state_s;

	icd_state_s s_q, s_d;

	// ---------------------------------------------------------------
	// decode of incoming opcode
	// ---------------------------------------------------------------
	logic [1:0] t_len; // decoded byte length
	logic [3:0] t_cyc; // not-taken cycles
	logic [3:0] t_tk; // taken cycles
	icd_class_e t_cls; // class
	icd_cond_e t_cond; // condition
	logic t_taken; // condition result

	icd_table u_table (
		.op(op),
		.len(t_len),
		.cyc(t_cyc),
		.cyc_tk(t_tk),
		.cls(t_cls),
		.cond(t_cond)
	);

	icd_cond u_cond (
		.cond(t_cond),
		.acc_zero(acc_zero),
		.carry(carry),
		.bit_val(bit_val),
		.ext_taken(ext_taken),
		.taken(t_taken)
	);

	// cycles an instruction needs given its outcome
	function automatic logic [3:0] icd_cycles(input logic [3:0] base,
		input logic [3:0] tk, input logic is_cond, input logic tkn);
		icd_cycles = (is_cond && tkn) ? tk : base;
	endfunction

	logic is_cond; // decoded as conditional
	assign is_cond = (t_cls == ICD_CL_COND) || (t_cls == ICD_CL_BITCLR);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// accept when idle or on the final cycle, so back-to-back works
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.bpls = 1'b0;
		case (s_q.st)
		ICD_ST_IDLE: begin
			s_d.st = ICD_ST_IDLE;
		end
		ICD_ST_RUN: begin
			if (s_q.idx + 4'h1 >= s_q.cyc) begin // one clock per cycle
				s_d.done = 1'b1;
				// pulse belongs to the ending opcode, not a follower
				s_d.bpls = s_q.bclr;
				s_d.st = ICD_ST_IDLE;
			end else begin
				s_d.idx = s_q.idx + 4'h1;
			end
		end
		default: s_d.st = ICD_ST_IDLE;
		endcase
		if (op_ready && op_valid) begin // new instruction
			s_d.st = ICD_ST_RUN;
			s_d.op = op;
			s_d.len = t_len;
			s_d.cyc = icd_cycles(t_cyc, t_tk, is_cond, t_taken);
			s_d.idx = ICD_RESET_CYC;
			s_d.taken = is_cond && t_taken;
			s_d.bclr = (t_cls == ICD_CL_BITCLR) && t_taken;
		end
		if (!rst_n) begin
			s_d = '0;
			s_d.st = ICD_ST_IDLE;
		end
	end

	// registered state
	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign op_ready = rst_n && ((s_q.st == ICD_ST_IDLE) ||
		(s_q.idx + 4'h1 >= s_q.cyc));
	assign busy = (s_q.st == ICD_ST_RUN);
	assign done = s_q.done;
	assign cur_op = s_q.op;
	assign cur_len = s_q.len;
	assign cur_cyc = s_q.cyc;
	assign cyc_idx = s_q.idx;
	assign cur_taken = s_q.taken;
	assign bit_clear = s_q.bpls;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence swap_start;
		op_ready && op_valid && op == 8'hC4;
	endsequence
	// three busy cycles, then a fourth busy cycle that offers the next slot
	sequence swap_run;
		busy [*3] ##1 busy && op_ready;
	endsequence
	swap_four_a: assert property (@(posedge clk) disable iff (!rst_n)
		swap_start |=> swap_run ##1 done)
		else $error("swap not four cycles");
	jnz_taken_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_ready && op_valid && op == 8'h70 && !acc_zero |=> cur_cyc == 4'h5
		&& cur_len == 2'h2) else $error("jnz taken not five");
	movc_pc_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_ready && op_valid && op == 8'h83 |=> cur_cyc == 4'h8)
		else $error("code read via pc not eight cycles");
	logic_reg_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_ready && op_valid && op[7:3] == 5'h0B |=> cur_cyc == 4'h1
		&& cur_len == 2'h1) else $error("register and wrong");
	jz_taken_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_ready && op_valid && op == 8'h60 && acc_zero |=> cur_cyc == 4'h5)
		else $error("jz taken not five");
	jc_ntaken_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_ready && op_valid && op == 8'h40 && !carry |=> cur_cyc == 4'h2)
		else $error("jc not taken not two");
	jbc_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		bit_clear |-> $past(cur_op) == 8'h10 && $past(cur_taken))
		else $error("bit clear outside taken jbc");
	dptr_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_ready && op_valid && op == 8'h90 |=> cur_len == 2'h3
		&& cur_cyc == 4'h3) else $error("dptr load wrong");
	done_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		done |-> $past(busy) && $past(cyc_idx) + 4'h1 >= $past(cur_cyc))
		else $error("done without final cycle");
	push_five_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_ready && op_valid && op == 8'hC0 |=> cur_cyc == 4'h5)
		else $error("push not five");
endmodule // icd_decoder

// ---- verif/icd_fetch_model.sv ----
// fetch side model: offers opcodes and flags to the decoder
`timescale 1ns/1ns
module icd_fetch_model (
	input wire logic clk,
	input wire logic op_ready,
	output logic op_valid,
	output logic [7:0] op,
	output logic acc_zero,
	output logic carry,
	output logic bit_val,
	output logic ext_taken
);
	// ---------------------------------------------------------------
	// idle state
	// ---------------------------------------------------------------
	// nothing offered, lines show a junk pattern
	initial begin
		op_valid = 1'b0;
		op = 8'hA5;
		{acc_zero, carry, bit_val, ext_taken} = 4'hA;
	end

	// ---------------------------------------------------------------
	// request
	// ---------------------------------------------------------------
	// offer one opcode, hold it until taken; ok low on timeout
	task automatic issue(input logic [7:0] o, input logic [3:0] fl,
		output bit ok);
		int k;
		ok = 1'b0;
		@(posedge clk);
		op_valid <= 1'b1;
		op <= o;
		{acc_zero, carry, bit_val, ext_taken} <= fl;
		for (k = 0; k < 20 && !ok; k++) begin
			// ready seen mid-cycle means taken at the coming edge
			@(negedge clk);
			ok = (op_ready === 1'b1);
			@(posedge clk);
		end
		// released lines invert so a stale value never matches
		op_valid <= 1'b0;
		op <= ~o;
		{acc_zero, carry, bit_val, ext_taken} <= ~fl;
	endtask
endmodule // icd_fetch_model

// ---- verif/test_instruction_cycle_decoder.sv ----
// self-checking bench of the instruction cycle decoder
`timescale 1ns/1ns
module test_instruction_cycle_decoder;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clk;
	logic rst_n;
	logic op_valid;
	logic [7:0] op;
	logic acc_zero;
	logic carry;
	logic bit_val;
	logic ext_taken;
	logic op_ready;
	logic busy;
	logic done;
	logic [7:0] cur_op;
	logic [1:0] cur_len;
	logic [3:0] cur_cyc;
	logic [3:0] cyc_idx;
	logic cur_taken;
	logic bit_clear;
	int n_fail = 0;
	int checks_done = 0;

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	icd_decoder u_dut (.clk, .rst_n, .op_valid, .op, .acc_zero, .carry,
		.bit_val, .ext_taken, .op_ready, .busy, .done, .cur_op, .cur_len,
		.cur_cyc, .cyc_idx, .cur_taken, .bit_clear);

	icd_fetch_model u_mem (.clk, .op_ready, .op_valid, .op, .acc_zero,
		.carry, .bit_val, .ext_taken);

	// ---------------------------------------------------------------
	// checking
	// ---------------------------------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// byte-wide results
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// single-bit results
	task automatic chk_bit(input logic got, input logic exp);
		chk(8'(got), 8'(exp));
	endtask

	// a bound ran out: count it and stop
	task automatic timeout();
		n_fail++;
		final_report();
	endtask

	// count edges until done, compare with n
	task automatic wait_done(input logic [3:0] n);
		int k;
		for (k = 1; k <= 20; k++) begin
			@(posedge clk);
			#1;
			if (done === 1'b1)
				break;
		end
		if (k > 20)
			timeout();
		chk(8'(k), 8'(n));
	endtask

	// one isolated opcode; lc: length high nibble, cycles low nibble
	// x: bit2 check outcome, bit1 expected outcome, bit0 bit clear
	task automatic run(input logic [7:0] o, input logic [7:0] lc,
		input logic [3:0] fl = 4'h0, input logic [2:0] x = 3'h0);
		bit ok;
		u_mem.issue(o, fl, ok);
		if (!ok)
			timeout();
		// first execution cycle shows right after the taking edge
		#1;
		chk_bit(busy, 1'b1);
		chk(cur_op, o);
		chk(8'(cyc_idx), 8'h00);
		wait_done(lc[3:0]);
		chk_bit(busy, 1'b0);
		chk(8'(cur_len), 8'(lc[5:4]));
		chk(8'(cur_cyc), 8'(lc[3:0]));
		chk(8'(cyc_idx), 8'(lc[3:0] - 4'h1));
		chk_bit(bit_clear, x[0]);
		if (x[2])
			chk_bit(cur_taken, x[1]);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_alu();
		run(8'h58, 8'h11);
		run(8'h4F, 8'h11);
		run(8'h6B, 8'h11);
		run(8'h55, 8'h22);
		run(8'h56, 8'h12);
		run(8'h54, 8'h22);
		run(8'h67, 8'h12);
		run(8'h52, 8'h23);
		run(8'h63, 8'h33);
		run(8'hE4, 8'h11);
		run(8'hF4, 8'h11);
		run(8'h23, 8'h11);
		run(8'h13, 8'h11);
		run(8'hC3, 8'h11);
		run(8'hB3, 8'h11);
		run(8'hC4, 8'h14);
		run(8'h28, 8'h11);
		run(8'hA4, 8'h14);
		run(8'hD4, 8'h11);
		run(8'h05, 8'h23);
		$display("test alu done");
	endtask

	task automatic t_bits();
		run(8'hC2, 8'h23);
		run(8'hD2, 8'h23);
		run(8'h92, 8'h23);
		run(8'h82, 8'h22);
		run(8'hB0, 8'h22);
		run(8'h72, 8'h22);
		run(8'hA2, 8'h22);
		$display("test bits done");
	endtask

	task automatic t_moves();
		run(8'hE8, 8'h11);
		run(8'hE5, 8'h22);
		run(8'hE6, 8'h12);
		run(8'h74, 8'h22);
		run(8'hF8, 8'h12);
		run(8'hAF, 8'h23);
		run(8'h78, 8'h22);
		run(8'h88, 8'h22);
		run(8'h85, 8'h33);
		run(8'h86, 8'h23);
		run(8'h75, 8'h33);
		run(8'hF6, 8'h12);
		run(8'hA7, 8'h23);
		run(8'h76, 8'h22);
		run(8'h90, 8'h33);
		run(8'h93, 8'h17);
		run(8'h83, 8'h18);
		run(8'hE2, 8'h15);
		run(8'hF0, 8'h15);
		run(8'hF2, 8'h14);
		run(8'hC0, 8'h25);
		run(8'hD0, 8'h24);
		run(8'hC8, 8'h13);
		run(8'hC5, 8'h24);
		run(8'hD6, 8'h14);
		$display("test moves done");
	endtask

	// flags: acc_zero, carry, bit_val, ext_taken
	task automatic t_branch();
		run(8'h01, 8'h24);
		run(8'h02, 8'h35);
		run(8'h80, 8'h24);
		run(8'h73, 8'h16);
		run(8'h11, 8'h27);
		run(8'h12, 8'h37);
		run(8'h32, 8'h18);
		run(8'h60, 8'h25, 4'h8, 3'h6);
		run(8'h60, 8'h23, 4'h0, 3'h4);
		run(8'h70, 8'h25, 4'h0, 3'h6);
		run(8'h40, 8'h24, 4'h4, 3'h6);
		run(8'h50, 8'h22, 4'h4, 3'h4);
		run(8'h20, 8'h36, 4'h2, 3'h6);
		run(8'h30, 8'h34, 4'h2, 3'h4);
		run(8'h10, 8'h36, 4'h2, 3'h7);
		run(8'h10, 8'h34, 4'h0, 3'h4);
		run(8'hB5, 8'h36, 4'h1, 3'h6);
		run(8'hB4, 8'h34, 4'h0, 3'h4);
		run(8'hB6, 8'h36, 4'h1, 3'h6);
		run(8'hD8, 8'h25, 4'h1, 3'h6);
		run(8'hD5, 8'h34, 4'h0, 3'h4);
		$display("test branch done");
	endtask

	// second opcode waits for the last cycle of the first
	task automatic t_b2b();
		bit ok;
		time t0;
		u_mem.issue(8'hC4, 4'h0, ok);
		if (!ok)
			timeout();
		t0 = $time;
		u_mem.issue(8'hE0, 4'h0, ok);
		if (!ok)
			timeout();
		chk(8'(($time - t0) / 100), 8'h04);
		#1;
		chk_bit(done, 1'b1);
		chk(cur_op, 8'hE0);
		wait_done(4'h6);
		$display("test b2b done");
	endtask

	// reset in mid-run clears the sequencer
	task automatic t_reset();
		bit ok;
		u_mem.issue(8'h83, 4'h0, ok);
		if (!ok)
			timeout();
		repeat (3) @(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		#1;
		chk_bit(busy, 1'b0);
		chk_bit(done, 1'b0);
		chk_bit(op_ready, 1'b0);
		chk(cur_op, 8'h00);
		@(posedge clk);
		rst_n <= 1'b1;
		run(8'h00, 8'h11);
		$display("test reset done");
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_alu();
		t_bits();
		t_moves();
		t_branch();
		t_b2b();
		t_reset();
		final_report();
	end
endmodule // test_instruction_cycle_decoder
